// >>> logic/amc_pkg.sv
// package: constants and carriers for amp mode and power-up control
package amc_pkg;
    // clock
    localparam int CLK_MHZ          = 200;
    // times in ms as printed
    localparam int START_MS         = 18;
    localparam int TIMEOUT_MS       = 25;
    localparam int OFF_MS           = 1;
    localparam int DWELL_MS         = 800;
    // cycles per millisecond tick
    localparam int TICK_CYCLES      = CLK_MHZ * 1000;
    localparam int TICK_W           = 18;
    localparam int MS_W             = 10;
    // switching rates in kHz
    localparam int RATE_STD_KHZ     = 192;
    localparam int RATE_RED_KHZ     = 76;
    // reset values
    localparam logic [MS_W-1:0]   MS_RST   = 10'h000;
    localparam logic [TICK_W-1:0] TICK_RST = 18'h00000;

    typedef enum logic [3:0] {
        MODE_STD     = 4'h1,
        MODE_RED     = 4'h2,
        MODE_HYB     = 4'h4,
        MODE_RED_HYB = 4'h8
    } amc_mode_type;

    typedef enum logic [3:0] {
        PW_OFF   = 4'h1,
        PW_START = 4'h2,
        PW_ZC    = 4'h4,
        PW_RUN   = 4'h8
    } amc_pw_type;

    // output stage control
    typedef struct packed {
        logic outputs_active;
        logic outputs_hiz;
        logic low_rail_sel;
        logic reduced_rate;
    } amc_out_type;

    // analog comparator levels
    typedef struct packed {
        logic below_low_rail_entry;
        logic above_battery_entry;
        logic battery_ok;
        logic zero_cross;
    } amc_sense_type;
endpackage

// >>> logic/amc_sync.sv
// two flip-flop synchroniser for a bus of levels
`timescale 1ns/10ps
module amc_sync
    import amc_pkg::*;
#(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         rst_n,
    // levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// >>> logic/amc_ms_timer.sv
// millisecond tick generator and elapsed-ms counter
`timescale 1ns/10ps
module amc_ms_timer
    import amc_pkg::*;
#(
    parameter int TICKS = TICK_CYCLES
) (
    // clock and reset
    input  wire logic            clock,
    input  wire logic            rst_n,
    // control
    input  wire logic            clear,
    // elapsed time
    output logic      [MS_W-1:0] ms_count
);
    logic [TICK_W-1:0] tick_r;
    wire               tick_end = (tick_r == TICK_W'(TICKS - 1));
    wire               ms_full  = (ms_count == {MS_W{1'b1}});

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tick_r   <= TICK_RST;
            ms_count <= MS_RST;
        end else if (clear) begin
            tick_r   <= TICK_RST;
            ms_count <= MS_RST;
        end else begin
            tick_r <= tick_end ? TICK_RST : tick_r + 1'b1;
            if (tick_end && !ms_full) begin
                ms_count <= ms_count + 1'b1;
            end
        end
    end
endmodule

// >>> logic/amc_ctrl.sv
// amp mode decode, rate and rail selection, power-up sequencing
// Functional notes
// - mode pin and strap select four modes
// - standard mode: 192 kHz, battery rail
// - reduced mode: 76 kHz at all levels
// - low battery forces standard mode when strap low
// - hybrid mode: 192 kHz, rail follows input
// - hybrid modes: low rail when quiet
// - reduced hybrid: 76 kHz loud, 192 quiet
// - idle rate equal in both hybrid modes
// - wait 18 ms start-up after release
// - outputs active by 18 plus 25 ms
// - power-down within 1 ms
// - low rail after 800 ms quiet dwell
// - battery rail when input above entry
// - enable at zero crossing or timeout
// - shutdown low: outputs hi-z, low power
`timescale 1ns/10ps
module amc_ctrl
    import amc_pkg::*;
#(
    parameter int TICKS    = TICK_CYCLES,
    parameter int START_T  = START_MS,
    parameter int TOUT_T   = TIMEOUT_MS,
    parameter int DWELL_T  = DWELL_MS
) (
    // clock and reset
    input  wire logic          clock,
    input  wire logic          resetn,
    // host pins
    input  wire logic          shutdown_n,
    input  wire logic          mode_pin,
    input  wire logic          rail_filter_strap,
    // analog comparators
    input  wire amc_sense_type sense,
    // output stage control
    output amc_out_type        out_ctl,
    output amc_mode_type       mode_now,
    output logic               low_power
);
    logic            rst_meta_r;
    logic            rst_n_r;
    logic [6:0]      pins_s;
    amc_pw_type      pw_r;
    amc_pw_type      pw_nxt;
    logic            low_rail_r;
    logic [MS_W-1:0] pw_ms;
    logic [MS_W-1:0] dw_ms;

    // reset release
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    wire [6:0] pins_raw = {shutdown_n, mode_pin, rail_filter_strap, sense};
    amc_sync #(.W(7)) u_sync (
        .clock (clock),
        .rst_n (rst_n_r),
        .d     (pins_raw),
        .q     (pins_s)
    );

    wire sd_s    = pins_s[6];
    wire mode_s  = pins_s[5];
    wire strap_s = pins_s[4];
    wire quiet_s = pins_s[3];
    wire loud_s  = pins_s[2];
    wire batt_s  = pins_s[1];
    wire zc_s    = pins_s[0];

    // strap high = tied to battery, low = filter cap
    wire hyb_ok = !strap_s && batt_s;
    wire amc_mode_type mode_dec =
        (!hyb_ok && !strap_s) ? MODE_STD :
        (strap_s && !mode_s)  ? MODE_RED :
        strap_s               ? MODE_STD :
        !mode_s               ? MODE_RED_HYB : MODE_HYB;
    wire is_hyb = (mode_dec == MODE_HYB) || (mode_dec == MODE_RED_HYB);

    // power sequencing timer, cleared in shutdown and on state change
    wire pw_clr = !sd_s || (pw_r != pw_nxt);
    amc_ms_timer #(.TICKS(TICKS)) u_pw_tmr (
        .clock    (clock),
        .rst_n    (rst_n_r),
        .clear    (pw_clr),
        .ms_count (pw_ms)
    );

    // quiet dwell timer, restarted whenever input is not quiet
    wire dw_clr = !sd_s || !quiet_s || !is_hyb;
    amc_ms_timer #(.TICKS(TICKS)) u_dw_tmr (
        .clock    (clock),
        .rst_n    (rst_n_r),
        .clear    (dw_clr),
        .ms_count (dw_ms)
    );

    wire start_done = (pw_ms >= MS_W'(START_T));
    wire tout_done  = (pw_ms >= MS_W'(TOUT_T));
    wire dwell_done = (dw_ms >= MS_W'(DWELL_T));

    always_comb begin
        pw_nxt = pw_r;
        case (pw_r)
            PW_OFF: begin
                if (sd_s) pw_nxt = PW_START;
            end
            PW_START: begin
                if (!sd_s) pw_nxt = PW_OFF;
                else if (start_done) pw_nxt = PW_ZC;
            end
            PW_ZC: begin
                if (!sd_s) pw_nxt = PW_OFF;
                else if (zc_s || tout_done) pw_nxt = PW_RUN;
            end
            PW_RUN: begin
                if (!sd_s) pw_nxt = PW_OFF;
            end
            default: pw_nxt = PW_OFF;
        endcase
    end

    // rail choice: battery when loud, low rail after dwell
    wire low_rail_nxt = (!is_hyb || loud_s) ? 1'b0 :
                        dwell_done ? 1'b1 : low_rail_r;
    // rate: reduced mode always, reduced hybrid only when loud
    wire red_rate = (mode_dec == MODE_RED) ||
                    (mode_dec == MODE_RED_HYB && loud_s && !low_rail_r);
    wire running  = (pw_nxt == PW_RUN);

    always_ff @(posedge clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pw_r       <= PW_OFF;
            low_rail_r <= 1'b0;
            out_ctl    <= '{outputs_active: 1'b0, outputs_hiz: 1'b1,
                            low_rail_sel: 1'b0, reduced_rate: 1'b0};
            mode_now   <= MODE_STD;
            low_power  <= 1'b1;
        end else begin
            pw_r       <= pw_nxt;
            low_rail_r <= sd_s && low_rail_nxt;
            out_ctl.outputs_active <= running;
            out_ctl.outputs_hiz    <= !running;
            out_ctl.low_rail_sel   <= sd_s && low_rail_nxt;
            out_ctl.reduced_rate   <= red_rate;
            mode_now   <= mode_dec;
            low_power  <= (pw_nxt == PW_OFF);
        end
    end

    // power-up watch: cycles since release while outputs idle
    localparam int UP_LIM = (START_T + TOUT_T) * TICKS + 8;
    localparam int UP_W   = $clog2(UP_LIM + 2);
    logic [UP_W-1:0] up_cnt_r;

    always_ff @(posedge clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            up_cnt_r <= '0;
        end else if (!sd_s || out_ctl.outputs_active) begin
            up_cnt_r <= '0;
        end else if (up_cnt_r != '1) begin
            up_cnt_r <= up_cnt_r + 1'b1;
        end
    end

    // assertions
    property p_hiz_when_off;
        @(posedge clock) disable iff (!rst_n_r)
        !sd_s |=> out_ctl.outputs_hiz && !out_ctl.outputs_active;
    endproperty
    a_hiz_when_off: assert property (p_hiz_when_off) else $error("not hi-z when off");

    property p_off_fast;
        @(posedge clock) disable iff (!rst_n_r)
        $fell(sd_s) |-> ##[1:2] low_power;
    endproperty
    a_off_fast: assert property (p_off_fast) else $error("power-down late");

    property p_std_rate;
        @(posedge clock) disable iff (!rst_n_r)
        (mode_dec == MODE_STD || mode_dec == MODE_HYB) |=> !out_ctl.reduced_rate;
    endproperty
    a_std_rate: assert property (p_std_rate) else $error("wrong rate");

    property p_red_rate;
        @(posedge clock) disable iff (!rst_n_r)
        mode_dec == MODE_RED |=> out_ctl.reduced_rate;
    endproperty
    a_red_rate: assert property (p_red_rate) else $error("reduced rate missing");

    property p_loud_batt;
        @(posedge clock) disable iff (!rst_n_r)
        loud_s |=> !out_ctl.low_rail_sel;
    endproperty
    a_loud_batt: assert property (p_loud_batt) else $error("low rail while loud");

    property p_no_early;
        @(posedge clock) disable iff (!rst_n_r)
        (pw_r == PW_START && !start_done) |=> !out_ctl.outputs_active;
    endproperty
    a_no_early: assert property (p_no_early) else $error("outputs before start");

    property p_zc_on;
        @(posedge clock) disable iff (!rst_n_r)
        (pw_r == PW_ZC && sd_s && zc_s) |=> out_ctl.outputs_active;
    endproperty
    a_zc_on: assert property (p_zc_on) else $error("no enable at crossing");

    property p_clear;
        @(posedge clock) disable iff (!rst_n_r)
        !sd_s |=> pw_ms == MS_RST && dw_ms == MS_RST;
    endproperty
    a_clear: assert property (p_clear) else $error("timers not cleared");

    property p_lowbatt;
        @(posedge clock) disable iff (!rst_n_r)
        (!strap_s && !batt_s) |-> mode_dec == MODE_STD;
    endproperty
    a_lowbatt: assert property (p_lowbatt) else $error("hybrid with low battery");

    property p_std_batt;
        @(posedge clock) disable iff (!rst_n_r)
        !is_hyb |=> !out_ctl.low_rail_sel;
    endproperty
    a_std_batt: assert property (p_std_batt) else $error("low rail outside hybrid");

    property p_dwell_low;
        @(posedge clock) disable iff (!rst_n_r)
        (sd_s && is_hyb && dwell_done && !loud_s) |=> out_ctl.low_rail_sel;
    endproperty
    a_dwell_low: assert property (p_dwell_low) else $error("no low rail");

    property p_dwell_early;
        @(posedge clock) disable iff (!rst_n_r)
        $rose(out_ctl.low_rail_sel) |-> $past(dwell_done);
    endproperty
    a_dwell_early: assert property (p_dwell_early) else $error("low rail early");

    property p_fhd_loud;
        @(posedge clock) disable iff (!rst_n_r)
        (mode_dec == MODE_RED_HYB && loud_s && !out_ctl.low_rail_sel) |=> out_ctl.reduced_rate;
    endproperty
    a_fhd_loud: assert property (p_fhd_loud) else $error("loud rate not reduced");

    property p_fhd_quiet;
        @(posedge clock) disable iff (!rst_n_r)
        (mode_dec == MODE_RED_HYB && !loud_s) |=> !out_ctl.reduced_rate;
    endproperty
    a_fhd_quiet: assert property (p_fhd_quiet) else $error("idle rate reduced");

    property p_tout_on;
        @(posedge clock) disable iff (!rst_n_r)
        (pw_r == PW_ZC && sd_s && tout_done) |=> out_ctl.outputs_active;
    endproperty
    a_tout_on: assert property (p_tout_on) else $error("no enable at timeout");

    property p_off_lp;
        @(posedge clock) disable iff (!rst_n_r)
        !sd_s |=> low_power;
    endproperty
    a_off_lp: assert property (p_off_lp) else $error("not low power when off");

    property p_low_clr;
        @(posedge clock) disable iff (!rst_n_r)
        !sd_s |=> !out_ctl.low_rail_sel;
    endproperty
    a_low_clr: assert property (p_low_clr) else $error("low rail kept when off");

    property p_sync_pins;
        @(posedge clock) disable iff (!rst_n_r)
        $past(rst_n_r, 2) |-> pins_s == $past(pins_raw, 2);
    endproperty
    a_sync_pins: assert property (p_sync_pins) else $error("pin sync latency");

    property p_up_max;
        @(posedge clock) disable iff (!rst_n_r)
        up_cnt_r <= UP_W'(UP_LIM);
    endproperty
    a_up_max: assert property (p_up_max) else $error("power-up too slow");

    property p_up_min;
        @(posedge clock) disable iff (!rst_n_r)
        $rose(out_ctl.outputs_active) |-> up_cnt_r >= UP_W'(START_T * TICKS);
    endproperty
    a_up_min: assert property (p_up_min) else $error("power-up too early");

    // covers
    c_run: cover property (@(posedge clock) disable iff (!rst_n_r) $rose(out_ctl.outputs_active));
    c_low: cover property (@(posedge clock) disable iff (!rst_n_r) $rose(out_ctl.low_rail_sel));
    c_fhd: cover property (@(posedge clock) disable iff (!rst_n_r)
        mode_dec == MODE_RED_HYB && out_ctl.reduced_rate);
    c_tout: cover property (@(posedge clock) disable iff (!rst_n_r) pw_r == PW_ZC && tout_done);
    c_off: cover property (@(posedge clock) disable iff (!rst_n_r) $fell(out_ctl.outputs_active));
endmodule

// >>> bench/amc_host_model.sv
// host model driving shutdown and mode pins
`timescale 1ns/10ps
module amc_host_model
    import amc_pkg::*;
#(
    parameter int TICKS = 10
) (
    // clock
    input  wire logic clock,
    // host pins
    output logic      shutdown_n,
    output logic      mode_pin,
    output logic      rail_filter_strap
);
    int cyc;
    int last;
    initial begin
        shutdown_n = 1'b0;
        mode_pin = 1'b1;
        rail_filter_strap = 1'b1;
        cyc = 0;
        last = 0;
    end
    always @(posedge clock) cyc <= cyc + 1;
    // shutdown level held one ms at least
    task automatic set_shutdown(input logic lvl);
        while (cyc - last < TICKS + 1) @(posedge clock);
        @(posedge clock);
        shutdown_n <= lvl;
        last = cyc;
    endtask
    task automatic set_mode(input logic strap, input logic md);
        @(posedge clock);
        rail_filter_strap <= strap;
        mode_pin <= md;
    endtask
endmodule

// >>> bench/amc_ctrl_tb_top.sv
// self-checking bench for amp mode and power-up control
`timescale 1ns/10ps
module amc_ctrl_tb_top
    import amc_pkg::*;
();
    localparam int TK = 10;
    localparam int ST = 3;
    localparam int TO = 4;
    localparam int DW = 5;
    logic          clock;
    logic          resetn;
    logic          shutdown_n;
    logic          mode_pin;
    logic          rail_filter_strap;
    amc_sense_type sense;
    amc_out_type   out_ctl;
    amc_mode_type  mode_now;
    logic          low_power;
    int            errors;
    int            num_checks;
    amc_host_model #(.TICKS(TK)) host (
        .clock(clock), .shutdown_n(shutdown_n), .mode_pin(mode_pin),
        .rail_filter_strap(rail_filter_strap));
    amc_ctrl #(.TICKS(TK), .START_T(ST), .TOUT_T(TO), .DWELL_T(DW)) uut (
        .clock(clock), .resetn(resetn), .shutdown_n(shutdown_n), .mode_pin(mode_pin),
        .rail_filter_strap(rail_filter_strap), .sense(sense), .out_ctl(out_ctl),
        .mode_now(mode_now), .low_power(low_power));
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task automatic finish_test();
        if (errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [3:0] exp, input logic [3:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wait_bit(input int b, input logic lvl, input int max, output int n);
        n = 0;
        while (out_ctl[b] !== lvl) begin
            @(negedge clock);
            n++;
            if (n > max) begin
                errors++;
                $display("[FAIL] out_ctl bit %0d expected %b seen %b", b, lvl, out_ctl[b]);
                finish_test();
            end
        end
    endtask
    task automatic t_power(input logic zc, input int lo, input int hi);
        int n;
        @(posedge clock);
        sense.zero_cross <= zc;
        host.set_shutdown(1'b1);
        wait_bit(3, 1'b1, hi, n);
        check("power_up_not_early", 4'h1, {3'h0, n >= lo});
        check("outputs_hiz", 4'h0, {3'h0, out_ctl.outputs_hiz});
        check("low_power", 4'h0, {3'h0, low_power});
        @(posedge clock);
        sense.zero_cross <= 1'b0;
    endtask
    task automatic t_modes();
        logic [3:0]   tbl [7] = '{4'ha, 4'he, 4'h2, 4'h3, 4'h7, 4'h4, 4'h8};
        amc_mode_type em [7] = '{MODE_RED, MODE_STD, MODE_RED_HYB, MODE_RED_HYB,
                                 MODE_HYB, MODE_STD, MODE_RED};
        logic         er [7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
        for (int i = 0; i < 7; i++) begin
            host.set_mode(tbl[i][3], tbl[i][2]);
            sense.battery_ok <= tbl[i][1];
            sense.above_battery_entry <= tbl[i][0];
            repeat (6) @(negedge clock);
            check("mode_now", em[i], mode_now);
            check("reduced_rate", {3'h0, er[i]}, {3'h0, out_ctl.reduced_rate});
            check("low_rail_sel", 4'h0, {3'h0, out_ctl.low_rail_sel});
        end
    endtask
    task automatic t_dwell();
        int n;
        host.set_mode(1'b0, 1'b1);
        sense.battery_ok <= 1'b1;
        sense.above_battery_entry <= 1'b0;
        sense.below_low_rail_entry <= 1'b1;
        wait_bit(1, 1'b1, DW * TK + 8, n);
        check("dwell_not_early", 4'h1, {3'h0, n >= DW * TK});
        @(posedge clock);
        sense.above_battery_entry <= 1'b1;
        sense.below_low_rail_entry <= 1'b0;
        wait_bit(1, 1'b0, 4, n);
        check("low_rail_sel", 4'h0, {3'h0, out_ctl.low_rail_sel});
    endtask
    task automatic t_fhd_dwell();
        int n;
        host.set_mode(1'b0, 1'b0);
        sense.above_battery_entry <= 1'b0;
        sense.below_low_rail_entry <= 1'b1;
        wait_bit(1, 1'b1, DW * TK + 8, n);
        check("fhd_dwell_not_early", 4'h1, {3'h0, n >= DW * TK});
        check("fhd_quiet_rate", 4'h0, {3'h0, out_ctl.reduced_rate});
        @(posedge clock);
        sense.above_battery_entry <= 1'b1;
        sense.below_low_rail_entry <= 1'b0;
        wait_bit(1, 1'b0, 4, n);
        repeat (2) @(negedge clock);
        check("fhd_loud_rate", 4'h1, {3'h0, out_ctl.reduced_rate});
    endtask
    task automatic t_off();
        int n;
        host.set_shutdown(1'b0);
        wait_bit(2, 1'b1, 5, n);
        repeat (2) @(negedge clock);
        check("out_ctl_off", 4'h4, {out_ctl[3:1], 1'b0});
        check("low_power", 4'h1, {3'h0, low_power});
    endtask
    initial begin
        errors = 0;
        num_checks = 0;
        resetn = 1'b0;
        sense = 4'h2;
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        repeat (6) @(negedge clock);
        check("out_ctl_reset", 4'h4, out_ctl);
        check("low_power_reset", 4'h1, {3'h0, low_power});
        t_power(1'b1, ST * TK, ST * TK + 8);
        t_modes();
        t_dwell();
        t_fhd_dwell();
        t_off();
        t_power(1'b0, (ST + TO) * TK, (ST + TO) * TK + 8);
        t_off();
        finish_test();
    end
endmodule
